/* File: rtl/ipsc_pkg.sv */
// How it works
// - eight 16-bit read/write priority registers, four 4-bit level fields each
// - first register holds pins 0-3 high field down, second pins 4-7
// - third register dma channels, fourth to sixth timers 0-4 then serial 0, 1
// - eighth register: watchdog/bus controller, then i/o port, two reserved fields
// - seventh register: converter, transfer controller, compare timers 0 and 1
// - field value 0 is lowest level, 15 the highest, in between linear
// - watchdog and bus controller share one field value as their level
// - priority registers clear on power-on or manual reset, kept in standby
// - sense control register resets only on power-on reset
// - control bit 15 reads the synchronised nmi pin level, writes ignored
// - reserved control bits 14-9 and status bits 15-8 read zero
// - control bit 8 picks nmi edge: 0 falling, 1 rising
// - control bits 7-0 pick pin sense, pin 0 at bit 7: 0 level, 1 edge
// - status bits 7-0 flags, pin 0 at bit 7; level mode flag means pin low
// - edge mode sets a flag on a falling edge and holds it
// - edge mode flag clears on write 0 after it was read as 1
// - edge mode flag clears when the core acknowledges that pin's exception
// - edge mode flag clears when a transfer started by that pin completes
// - status register resets only on power-on reset, all flags zero
// - highest level wins; ties go to the lower source index
// - forward only when the level is above the core mask level
// - request output pin is low while a request is forwarded
package ipsc_pkg;
  localparam int unsigned PRI_REGS = 8;
  localparam int unsigned IRQ_PINS = 8;
  localparam int unsigned NUM_SRC = 31;
  localparam int unsigned NUM_PERIPH = 23;
  localparam int unsigned SRC_BSC = 29;
  localparam int unsigned SRC_IO = 30;
  localparam logic [7:0] OFS_PRI_BASE = 8'h00;
  localparam logic [7:0] OFS_ICR = 8'h20;
  localparam logic [7:0] OFS_ISR = 8'h24;
  localparam logic [15:0] PRI_RESET = 16'h0000;
  localparam int unsigned ICR_NMI_LEVEL_BIT = 15;
  localparam int unsigned ICR_NMI_EDGE_BIT = 8;
  localparam logic [3:0] SEL_ICR = 4'h8;
  localparam logic [3:0] SEL_ISR = 4'h9;
  localparam logic [3:0] SEL_NONE = 4'hf;

  typedef struct packed {
    logic [PRI_REGS-1:0][15:0] pri;
    logic nmi_edge_select;
    logic [7:0] sense;
    logic [7:0] flags;
    logic [7:0] armed;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] pin_prev;
    logic nmi_s1;
    logic nmi_s2;
    logic nmi_prev;
    logic nmi_pend;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    logic ready;
    logic resp;
    logic req_valid;
    logic [3:0] req_level;
    logic [4:0] req_src;
    logic out_n;
  } ipsc_state_t;
endpackage

/* File: rtl/ipsc_top.sv */
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ipsc_top
  import ipsc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_manual_reset_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_nmi_pin,
  input wire logic [IRQ_PINS-1:0] i_irq_pin_n,
  input wire logic [NUM_PERIPH-1:0] i_periph_req,
  input wire logic [3:0] i_cpu_mask_level,
  input wire logic i_exc_ack,
  input wire logic [4:0] i_exc_source,
  input wire logic i_dtc_done,
  input wire logic [4:0] i_dtc_source,
  input wire logic i_nmi_ack,
  output logic o_nmi_request,
  output logic o_req_valid,
  output logic [3:0] o_req_level,
  output logic [4:0] o_req_source,
  output logic o_request_out_n
);

  ////////////////////////////////////////////////////////////////////////////
  // decode and field helpers

  // register select code: 0-7 priority, icr, isr or none
  function automatic logic [3:0] reg_sel(input logic [7:0] addr);
    if (addr[7:5] == OFS_PRI_BASE[7:5] && addr[1:0] == 2'h0) begin
      return {1'b0, addr[4:2]};
    end else if (addr == OFS_ICR) begin
      return SEL_ICR;
    end else if (addr == OFS_ISR) begin
      return SEL_ISR;
    end
    return SEL_NONE;
  endfunction

  // level of a source; the bus controller reuses the watchdog field
  function automatic logic [3:0] src_level(input logic [PRI_REGS-1:0][15:0] pri,
                                           input int unsigned s);
    int unsigned f;
    f = (s < SRC_BSC) ? s : s - 1;
    return pri[f / 4][15 - 4 * (f % 4) -: 4];
  endfunction

  // readable word; reserved bits are forced to zero
  function automatic logic [31:0] rd_word(input ipsc_state_t s, input logic [3:0] sel);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (sel < SEL_ICR) begin
      w[15:0] = s.pri[sel[2:0]];
    end else if (sel == SEL_ICR) begin
      w[ICR_NMI_LEVEL_BIT] = s.nmi_s2;
      w[ICR_NMI_EDGE_BIT] = s.nmi_edge_select;
      w[7:0] = s.sense;
    end else if (sel == SEL_ISR) begin
      w[7:0] = s.flags;
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  ipsc_state_t r_reg;
  ipsc_state_t r_next;
  logic [NUM_SRC-1:0] src_req;
  logic addr_ok;
  logic [3:0] wr_sel;
  logic [3:0] rd_sel;

  // flag bit b belongs to pin 7-b, so the request vector is bit reversed
  always_comb begin
    for (int p = 0; p < IRQ_PINS; p++) begin
      src_req[p] = r_reg.flags[IRQ_PINS - 1 - p];
    end
    src_req[NUM_SRC-1:IRQ_PINS] = i_periph_req;
  end

  assign addr_ok = i_hsel && i_htrans[1] && i_hready;
  assign wr_sel = reg_sel(r_reg.wr_addr);
  assign rd_sel = reg_sel(i_haddr[7:0]);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic found;
    logic [3:0] best_lvl;
    logic [4:0] best_src;
    logic [3:0] lvl;
    logic clr;
    logic fall;
    int unsigned p;
    found = 1'b0;
    best_lvl = 4'h0;
    best_src = 5'h00;
    lvl = 4'h0;
    clr = 1'b0;
    fall = 1'b0;
    p = 0;
    r_next = r_reg;

    // pins pass two flops; only the second one is looked at
    r_next.pin_s1 = i_irq_pin_n;
    r_next.pin_s2 = r_reg.pin_s1;
    r_next.pin_prev = r_reg.pin_s2;
    r_next.nmi_s1 = i_nmi_pin;
    r_next.nmi_s2 = r_reg.nmi_s1;
    r_next.nmi_prev = r_reg.nmi_s2;
    r_next.ready = 1'b1;
    r_next.resp = 1'b0;

    // data phase of a write: the slave never stalls, so commit at once
    if (r_reg.wr_pend) begin
      if (wr_sel < SEL_ICR) begin
        r_next.pri[wr_sel[2:0]] = i_hwdata[15:0];
      end else if (wr_sel == SEL_ICR) begin
        r_next.nmi_edge_select = i_hwdata[ICR_NMI_EDGE_BIT];
        r_next.sense = i_hwdata[7:0];
      end
    end

    // nmi edge pending flag; a new edge wins over the acknowledge
    if (i_nmi_ack) begin
      r_next.nmi_pend = 1'b0;
    end
    if (r_reg.nmi_edge_select ? (r_reg.nmi_s2 && !r_reg.nmi_prev)
                   : (!r_reg.nmi_s2 && r_reg.nmi_prev)) begin
      r_next.nmi_pend = 1'b1;
    end

    // request flags, one per pin
    for (int b = 0; b < IRQ_PINS; b++) begin
      p = IRQ_PINS - 1 - b;
      fall = r_reg.pin_prev[p] && !r_reg.pin_s2[p];
      clr = (r_reg.wr_pend && wr_sel == SEL_ISR && !i_hwdata[b] && r_reg.armed[b])
          || (i_exc_ack && i_exc_source == 5'(p))
          || (i_dtc_done && i_dtc_source == 5'(p));
      if (!r_reg.sense[b]) begin
        r_next.flags[b] = !r_reg.pin_s2[p];
      end else begin
        r_next.flags[b] = fall || (r_reg.flags[b] && !clr);
      end
    end

    // a write to the status register uses up the earlier read
    if (r_reg.wr_pend && wr_sel == SEL_ISR) begin
      r_next.armed = 8'h00;
    end

    // address phase
    r_next.wr_pend = 1'b0;
    if (addr_ok) begin
      r_next.wr_pend = i_hwrite;
      r_next.wr_addr = i_haddr[7:0];
      if (!i_hwrite && rd_sel == SEL_ISR) begin
        r_next.armed = r_next.armed | r_reg.flags;
      end
    end

    // manual reset touches only the priority registers
    if (!i_manual_reset_n) begin
      r_next.pri = '0;
    end

    // read data taken after this cycle's write so back to back reads see it
    if (addr_ok && !i_hwrite) begin
      r_next.hrdata = rd_word(r_next, rd_sel);
      // nmi level from the second flop only; r_next holds the first one's copy
      if (rd_sel == SEL_ICR) begin
        r_next.hrdata[ICR_NMI_LEVEL_BIT] = r_reg.nmi_s2;
      end
    end

    // arbitration: strict greater keeps the lower index on a tie
    for (int s = 0; s < NUM_SRC; s++) begin
      lvl = src_level(r_reg.pri, s);
      if (src_req[s] && (!found || lvl > best_lvl)) begin
        found = 1'b1;
        best_lvl = lvl;
        best_src = 5'(s);
      end
    end
    r_next.req_valid = found && (best_lvl > i_cpu_mask_level);
    r_next.req_level = best_lvl;
    r_next.req_src = best_src;
    r_next.out_n = !r_next.req_valid;

    // power-on reset clears everything, status and control included, but loads ones into the pin flops and out_n
    if (!i_reset_n) begin
      r_next = '0;
      r_next.pri = {PRI_REGS{PRI_RESET}};
      r_next.out_n = 1'b1;
      // pins idle high; a zero here would fake a level request after reset
      r_next.pin_s1 = 8'hff;
      r_next.pin_s2 = 8'hff;
      r_next.pin_prev = 8'hff;
    end
  end

  // single register stage for all state
  always_ff @(posedge i_clk) begin
    r_reg <= r_next;
  end

  assign o_hrdata = r_reg.hrdata;
  assign o_hreadyout = r_reg.ready;
  assign o_hresp = r_reg.resp;
  assign o_nmi_request = r_reg.nmi_pend;
  assign o_req_valid = r_reg.req_valid;
  assign o_req_level = r_reg.req_level;
  assign o_req_source = r_reg.req_src;
  assign o_request_out_n = r_reg.out_n;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence isr_read_s;
    addr_ok && !i_hwrite && rd_sel == SEL_ISR;
  endsequence

  sequence isr_write_s;
    addr_ok && i_hwrite && rd_sel == SEL_ISR;
  endsequence

  pri_por_a: assert property (@(posedge i_clk)
    !i_reset_n |=> r_reg.pri == '0)
    else $error("priority registers not cleared by power-on reset");

  pri_manual_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !i_manual_reset_n |=> r_reg.pri == '0)
    else $error("priority registers not cleared by manual reset");

  ctl_keep_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !i_manual_reset_n && !(r_reg.wr_pend && wr_sel == SEL_ICR)
    |=> $stable(r_reg.sense) && $stable(r_reg.nmi_edge_select))
    else $error("manual reset disturbed sense control");

  nmi_level_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    addr_ok && !i_hwrite && rd_sel == SEL_ICR
    |=> o_hrdata[ICR_NMI_LEVEL_BIT] == $past(r_reg.nmi_s2))
    else $error("nmi level bit does not follow the pin");

  rsvd_zero_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    addr_ok && !i_hwrite && (rd_sel == SEL_ICR || rd_sel == SEL_ISR)
    |=> o_hrdata[14:9] == 6'h00 && ($past(rd_sel) != SEL_ISR || o_hrdata[15:8] == 8'h00))
    else $error("reserved bits read nonzero");

  nmi_edge_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    r_reg.nmi_edge_select && r_reg.nmi_s2 && !r_reg.nmi_prev ##1 !i_reset_n == 1'b0
    |-> o_nmi_request)
    else $error("rising nmi edge not caught");

  forward_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_req_valid |-> o_req_level > $past(i_cpu_mask_level))
    else $error("request forwarded at or below mask level");

  out_pin_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_request_out_n == !o_req_valid)
    else $error("request pin disagrees with forwarded request");

  generate
    for (genvar b = 0; b < IRQ_PINS; b++) begin : g_flag_chk
      level_flag_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !r_reg.sense[b] |=> r_reg.flags[b] == !$past(r_reg.pin_s2[IRQ_PINS-1-b]))
        else $error("level flag does not follow pin");

      edge_set_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        r_reg.sense[b] && r_reg.pin_prev[IRQ_PINS-1-b] && !r_reg.pin_s2[IRQ_PINS-1-b]
        |=> r_reg.flags[b])
        else $error("falling edge did not set flag");

      arm_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        isr_read_s ##0 r_reg.flags[b]
        |=> r_reg.armed[b])
        else $error("status read did not arm a set flag");

      withdraw_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        isr_write_s ##1
        (r_reg.sense[b] && !i_hwdata[b] && r_reg.armed[b]
         && !(r_reg.pin_prev[IRQ_PINS-1-b] && !r_reg.pin_s2[IRQ_PINS-1-b]))
        |=> !r_reg.flags[b])
        else $error("read then write zero did not clear flag");

      ack_clear_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        r_reg.sense[b] && i_exc_ack && i_exc_source == 5'(IRQ_PINS-1-b)
        && !(r_reg.pin_prev[IRQ_PINS-1-b] && !r_reg.pin_s2[IRQ_PINS-1-b])
        |=> !r_reg.flags[b])
        else $error("exception acknowledge did not clear flag");

      keep_one_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        r_reg.sense[b] && r_reg.flags[b] && !r_reg.armed[b] && !i_exc_ack && !i_dtc_done
        |=> r_reg.flags[b] || !$past(r_reg.sense[b]))
        else $error("flag lost without a clear condition");
    end
  endgenerate

endmodule // ipsc_top

/* File: tb/ipsc_core_model.sv */
`timescale 1ns/1ps
module ipsc_core_model #(
  parameter int unsigned DELAY = 3
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_enable,
  input wire logic i_req_valid,
  input wire logic [4:0] i_req_source,
  output logic o_exc_ack,
  output logic [4:0] o_exc_source
);
  logic [3:0] wait_reg;
  ////////////////////////////////////////////////////////////////////////////
  // core takes a forwarded request after DELAY + 1 cycles; between acks the
  // source lines carry the inverse so a stale value never looks valid
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wait_reg <= 4'h0;
      o_exc_ack <= 1'b0;
      o_exc_source <= 5'h1f;
    end else begin
      o_exc_ack <= 1'b0;
      o_exc_source <= ~i_req_source;
      if (i_enable && i_req_valid && !o_exc_ack) begin
        wait_reg <= wait_reg + 4'h1;
        if (wait_reg == 4'(DELAY)) begin
          o_exc_ack <= 1'b1;
          o_exc_source <= i_req_source;
          wait_reg <= 4'h0;
        end
      end else begin
        wait_reg <= 4'h0;
      end
    end
  end
endmodule // ipsc_core_model

/* File: tb/irq_priority_and_sense_control_tb.sv */
`timescale 1ns/1ps
module irq_priority_and_sense_control_tb;
  import ipsc_pkg::*;
  logic clk, rst_n, mrst_n, hsel, hwrite, nmi, ack_en, data_transfer_controller, nmi_ack;
  logic rdy, resp, eack, nreq, vld, out_n;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] pin_n;
  logic [22:0] preq;
  logic [3:0] mask, lvl;
  logic [4:0] dsrc, esrc, src;
  int mismatches = 0;
  int checks = 0;
  ////////////////////////////////////////////////////////////////////////////
  ipsc_top u_dut(.i_clk(clk), .i_reset_n(rst_n), .i_manual_reset_n(mrst_n), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(rdy), .o_hrdata(hrdata), .o_hreadyout(rdy), .o_hresp(resp),
    .i_nmi_pin(nmi), .i_irq_pin_n(pin_n), .i_periph_req(preq), .i_cpu_mask_level(mask),
    .i_exc_ack(eack), .i_exc_source(esrc), .i_dtc_done(data_transfer_controller), .i_dtc_source(dsrc),
    .i_nmi_ack(nmi_ack), .o_nmi_request(nreq), .o_req_valid(vld), .o_req_level(lvl),
    .o_req_source(src), .o_request_out_n(out_n));
  ipsc_core_model u_core(.i_clk(clk), .i_reset_n(rst_n), .i_enable(ack_en),
    .i_req_valid(vld), .i_req_source(src), .o_exc_ack(eack), .o_exc_source(esrc));
  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog; the run needs a few thousand cycles at most
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results;
  end
  ////////////////////////////////////////////////////////////////////////////
  // field value of the pattern: never zero, so every source can win
  function automatic logic [3:0] fv(input int r, input int f);
    return 4'((r * 4 + f) % 15 + 1);
  endfunction
  function automatic logic [15:0] pat(input int r);
    return {fv(r, 0), fv(r, 1), fv(r, 2), fv(r, 3)};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one single ahb transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(negedge clk);
    while (rdy !== 1'b1) @(negedge clk);
    @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(negedge clk);
    while (rdy !== 1'b1) @(negedge clk);
    d = hrdata;
    @(posedge clk);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [15:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, {16'h0, e}, d);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_n = 0; mrst_n = 1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2;
    hwdata = 0; nmi = 1; pin_n = 8'hff; preq = 0; mask = 0; ack_en = 0; data_transfer_controller = 0;
    dsrc = 0; nmi_ack = 0;
    tick(8);
    rst_n <= 1'b1;
    tick(2);
    for (int r = 0; r < 8; r++) rd("pri_reset", 8'(r * 4), 16'h0000);
    rd("ctl_reset", OFS_ICR, 16'h8000);
    rd("flag_reset", OFS_ISR, 16'h0000);
    rd("unmapped", 8'h28, 16'h0000);
    for (int r = 0; r < 8; r++) begin
      xfer(1'b1, 8'(r * 4), {16'hffff, pat(r)});
      rd("pri_rw", 8'(r * 4), pat(r));
    end
    // every peripheral source alone, with its level from the pattern
    for (int s = 8; s < 31; s++) begin
      preq <= 23'(1) << (s - 8);
      tick(3);
      chk("src", 32'(s), 32'(src));
      chk("lvl", 32'(s < 28 ? fv(s / 4, s % 4) : fv(7, s / 30)), 32'(lvl));
      chk("vld", 32'h1, 32'(vld));
    end
    // watchdog and bus controller tie on one field, level 14
    preq <= 23'h300000;
    tick(3);
    chk("tie_src", 32'd28, 32'(src));
    mask <= 4'he;
    tick(3);
    chk("mask_eq", 32'h1, {31'h0, out_n});
    mask <= 4'hd;
    tick(3);
    chk("mask_lt", 32'h0, {31'h0, out_n});
    preq <= 23'h0;
    // pin 1 edge sensed, pin 0 level sensed
    xfer(1'b1, OFS_ICR, 32'h0000_7e40);
    rd("ctl", OFS_ICR, 16'h8040);
    xfer(1'b1, OFS_ISR, 32'h0000_ff00);
    rd("flag_rsv", OFS_ISR, 16'h0000);
    xfer(1'b1, 8'h00, 32'h0000_5a00);
    mask <= 4'h3;
    pin_n <= 8'hfc;
    tick(5);
    chk("pin_src", 32'h1, 32'(src));
    chk("pin_lvl", 32'ha, 32'(lvl));
    pin_n <= 8'hff;
    tick(5);
    xfer(1'b1, OFS_ISR, 32'h0);
    rd("flag_held", OFS_ISR, 16'h0040);
    xfer(1'b1, OFS_ISR, 32'h0);
    rd("flag_clr", OFS_ISR, 16'h0000);
    // exception taken by the core clears the edge flag
    pin_n <= 8'hfd;
    tick(5);
    ack_en <= 1'b1;
    tick(12);
    ack_en <= 1'b0;
    rd("flag_exc", OFS_ISR, 16'h0000);
    // completed transfer clears the edge flag
    pin_n <= 8'hff;
    tick(4);
    pin_n <= 8'hfd;
    tick(5);
    chk("out_low", 32'h0, {31'h0, out_n});
    data_transfer_controller <= 1'b1;
    dsrc <= 5'd1;
    tick(1);
    data_transfer_controller <= 1'b0;
    tick(2);
    rd("flag_dtc", OFS_ISR, 16'h0000);
    // nmi falling edge, then rising edge once selected
    nmi <= 1'b0;
    tick(5);
    chk("nmi_fall", 32'h1, {31'h0, nreq});
    rd("nmi_lvl", OFS_ICR, 16'h0040);
    nmi_ack <= 1'b1;
    tick(1);
    nmi_ack <= 1'b0;
    tick(2);
    chk("nmi_ack", 32'h0, {31'h0, nreq});
    xfer(1'b1, OFS_ICR, 32'h0000_0140);
    nmi <= 1'b1;
    tick(5);
    chk("nmi_rise", 32'h1, {31'h0, nreq});
    // manual reset clears priorities only
    mrst_n <= 1'b0;
    tick(1);
    mrst_n <= 1'b1;
    tick(1);
    rd("pri_mrst", 8'h00, 16'h0000);
    rd("ctl_mrst", OFS_ICR, 16'h8140);
    results;
  end
endmodule // irq_priority_and_sense_control_tb
